// ==== fst_defs.svh ====
// Constants for the flash status and lock tracking host controller
`ifndef FST_DEFS_SVH
`define FST_DEFS_SVH
`define FST_REG_CTRL 4'h0
`define FST_REG_CMD 4'h1
`define FST_REG_STATUS 4'h2
`define FST_REG_XSTATUS 4'h3
`define FST_REG_LOCK 4'h4
`define FST_BIT_READY 15
`define FST_BIT_ESUSP 14
`define FST_BIT_EERR 13
`define FST_BIT_PERR 12
`define FST_BIT_VERR 11
`define FST_BIT_PSUSP 10
`define FST_BIT_LOCKERR 9
`define FST_BIT_PBAVAIL 7
`define FST_SR_MASK 16'hfe00
`define FST_XSR_MASK 16'h0080
`define FST_CMD_READ_STATUS 16'h0070
`define FST_CMD_CLEAR_STATUS 16'h0050
`define FST_CMD_READ_ID 16'h0090
`define FST_CMD_PB_SETUP 16'h00e8
`define FST_BUS_PULSE 4'h4
`endif

// ==== fst_pkg.sv ====
// Types for the flash status and lock tracking host controller
package fst_pkg;
  typedef enum logic [2:0] {
    FST_IDLE, FST_WR, FST_WR_GAP, FST_RD, FST_DONE
  } fst_state_t;
  typedef enum logic [1:0] {
    FST_OP_WRITE, FST_OP_READ_SR, FST_OP_READ_XSR, FST_OP_READ_ID
  } fst_op_t;
endpackage

// ==== fst_host.sv ====
// Host controller that polls flash status words and drives the protect pin
`timescale 1ns/10ps
`include "fst_defs.svh"
module fst_host
  import fst_pkg::*;
#(
  parameter int ADDR_W = 23
) (
  // Clock and reset
  input wire logic sys_clk_in,
  input wire logic rst_in,
  // AXI4-Lite slave
  input wire logic [31:0] s_awaddr_in,
  input wire logic s_awvalid_in,
  output logic s_awready_out,
  input wire logic [31:0] s_wdata_in,
  input wire logic [3:0] s_wstrb_in,
  input wire logic s_wvalid_in,
  output logic s_wready_out,
  output logic [1:0] s_bresp_out,
  output logic s_bvalid_out,
  input wire logic s_bready_in,
  input wire logic [31:0] s_araddr_in,
  input wire logic s_arvalid_in,
  output logic s_arready_out,
  output logic [31:0] s_rdata_out,
  output logic [1:0] s_rresp_out,
  output logic s_rvalid_out,
  input wire logic s_rready_in,
  // Flash pins
  output logic [ADDR_W-1:0] flash_addr_out,
  output logic [15:0] flash_dq_out,
  output logic flash_dq_oe_out,
  input wire logic [15:0] flash_dq_in,
  output logic flash_ce_n_out,
  output logic flash_we_n_out,
  output logic flash_oe_n_out,
  output logic protect_accel_pin_out,
  input wire logic engine_busy_pin_n_in
);
  fst_state_t state_ff;
  fst_op_t op_ff;
  logic [3:0] cnt_ff;
  logic [15:0] sr_ff, xsr_ff, lock_ff;
  logic [15:0] dq_s1_ff, dq_s2_ff;
  logic busy_s1_ff, busy_s2_ff;
  logic [ADDR_W-1:0] tgt_addr_ff;
  logic [1:0] op_req_ff;
  logic go_ff;
  logic [15:0] cmd_data_ff;
  logic aw_got_ff, w_got_ff;
  logic [31:0] awaddr_ff, wdata_ff;
  logic [3:0] wstrb_ff;
  logic [2:0] seq_ff;

  // Register index from a byte address
  function automatic logic [3:0] reg_idx(input logic [31:0] a);
    reg_idx = a[5:2];
  endfunction

  // Two-flop synchronisers on pins from the flash
  always_ff @(posedge sys_clk_in) begin
    dq_s1_ff <= flash_dq_in;
    dq_s2_ff <= dq_s1_ff;
    busy_s1_ff <= engine_busy_pin_n_in;
    busy_s2_ff <= busy_s1_ff;
  end

  // Write channel capture; address and data may come in either order
  wire wr_fire = aw_got_ff && w_got_ff && !s_bvalid_out;
  wire wr_ok = wr_fire && wstrb_ff == 4'hf; // Partial-word writes are dropped
  wire nxt_aw_got = (aw_got_ff || (s_awvalid_in && s_awready_out)) && !wr_fire;
  wire nxt_w_got = (w_got_ff || (s_wvalid_in && s_wready_out)) && !wr_fire;
  wire nxt_bvalid = wr_fire || (s_bvalid_out && !s_bready_in);
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      aw_got_ff <= 1'b0;
      w_got_ff <= 1'b0;
      awaddr_ff <= 32'h0;
      wdata_ff <= 32'h0;
      wstrb_ff <= 4'h0;
      s_bvalid_out <= 1'b0;
      s_awready_out <= 1'b0;
      s_wready_out <= 1'b0;
      s_bresp_out <= 2'h0;
    end else begin
      if (s_awvalid_in && s_awready_out) begin
        awaddr_ff <= s_awaddr_in;
      end
      if (s_wvalid_in && s_wready_out) begin
        wdata_ff <= s_wdata_in;
        wstrb_ff <= s_wstrb_in;
      end
      aw_got_ff <= nxt_aw_got;
      w_got_ff <= nxt_w_got;
      s_bvalid_out <= nxt_bvalid;
      s_awready_out <= !nxt_aw_got && !nxt_bvalid; // Registered, so it looks one state ahead
      s_wready_out <= !nxt_w_got && !nxt_bvalid;
      s_bresp_out <= 2'h0;
    end
  end

  // Control, command and lock registers: protect pin, operation kind and command data, flash address
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      go_ff <= 1'b0;
      op_req_ff <= 2'h0;
      tgt_addr_ff <= '0;
      cmd_data_ff <= 16'h0;
      protect_accel_pin_out <= 1'b0;
    end else begin
      go_ff <= 1'b0;
      if (wr_ok && reg_idx(awaddr_ff) == `FST_REG_CTRL) begin
        protect_accel_pin_out <= wdata_ff[0];
      end
      // Orders are refused while one is pending or running
      if (wr_ok && reg_idx(awaddr_ff) == `FST_REG_CMD && state_ff == FST_IDLE && !go_ff) begin
        op_req_ff <= wdata_ff[17:16];
        cmd_data_ff <= wdata_ff[15:0];
        go_ff <= 1'b1;
      end
      if (wr_ok && reg_idx(awaddr_ff) == `FST_REG_LOCK) begin
        tgt_addr_ff <= wdata_ff[ADDR_W-1:0];
      end
    end
  end

  // Flash bus sequencer: status reads issue a command write, then a read
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      state_ff <= FST_IDLE;
      op_ff <= FST_OP_WRITE;
      cnt_ff <= 4'h0;
      seq_ff <= 3'h0;
      flash_addr_out <= '0;
      flash_dq_out <= 16'h0;
      flash_dq_oe_out <= 1'b0;
      flash_ce_n_out <= 1'b1;
      flash_we_n_out <= 1'b1;
      flash_oe_n_out <= 1'b1;
      sr_ff <= 16'h0;
      xsr_ff <= 16'h0;
      lock_ff <= 16'h0;
    end else begin
      unique case (state_ff)
        FST_IDLE: begin
          if (go_ff) begin
            op_ff <= fst_op_t'(op_req_ff);
            flash_addr_out <= tgt_addr_ff;
            flash_dq_oe_out <= 1'b1;
            flash_ce_n_out <= 1'b0;
            flash_we_n_out <= 1'b0;
            cnt_ff <= `FST_BUS_PULSE;
            state_ff <= FST_WR;
            unique case (fst_op_t'(op_req_ff))
              FST_OP_WRITE: flash_dq_out <= cmd_data_ff;
              FST_OP_READ_SR: flash_dq_out <= `FST_CMD_READ_STATUS;
              FST_OP_READ_XSR: flash_dq_out <= `FST_CMD_PB_SETUP;
              FST_OP_READ_ID: flash_dq_out <= `FST_CMD_READ_ID;
            endcase
          end
        end
        FST_WR: begin
          if (cnt_ff != 4'h0) begin
            cnt_ff <= cnt_ff - 4'h1;
          end else begin
            flash_we_n_out <= 1'b1; // Chip select held past the strobe for data hold
            cnt_ff <= `FST_BUS_PULSE;
            state_ff <= (op_ff == FST_OP_WRITE) ? FST_DONE : FST_WR_GAP;
          end
        end
        FST_WR_GAP: begin
          flash_dq_oe_out <= 1'b0;
          flash_oe_n_out <= 1'b0;
          cnt_ff <= `FST_BUS_PULSE + 4'h3; // Pulse plus synchroniser delay
          state_ff <= FST_RD;
        end
        FST_RD: begin
          if (cnt_ff != 4'h0) begin
            cnt_ff <= cnt_ff - 4'h1;
          end else begin
            flash_oe_n_out <= 1'b1;
            flash_ce_n_out <= 1'b1;
            unique case (op_ff)
              FST_OP_READ_SR: sr_ff <= dq_s2_ff & `FST_SR_MASK;
              FST_OP_READ_XSR: xsr_ff <= dq_s2_ff & `FST_XSR_MASK;
              FST_OP_READ_ID: lock_ff <= dq_s2_ff & 16'h0003;
              default: lock_ff <= lock_ff;
            endcase
            state_ff <= FST_DONE;
          end
        end
        FST_DONE: begin
          flash_ce_n_out <= 1'b1;
          seq_ff <= seq_ff + 3'h1;
          state_ff <= FST_IDLE;
        end
      endcase
    end
  end

  // Error bits only count once ready; while busy they read as zero
  wire [15:0] sr_view = sr_ff[`FST_BIT_READY] ? sr_ff : {sr_ff[15], 6'h0, sr_ff[8:0]};
  // Read channel: one read at a time, data straight from flops
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      s_rvalid_out <= 1'b0;
      s_rdata_out <= 32'h0;
      s_rresp_out <= 2'h0;
      s_arready_out <= 1'b0;
    end else begin
      s_arready_out <= !s_rvalid_out && !s_arready_out;
      if (s_arvalid_in && s_arready_out) begin
        s_arready_out <= 1'b0;
        s_rvalid_out <= 1'b1;
        s_rresp_out <= 2'h0;
        unique case (reg_idx(s_araddr_in))
          `FST_REG_CTRL: s_rdata_out <= {31'h0, protect_accel_pin_out};
          `FST_REG_CMD: s_rdata_out <= {
            busy_s2_ff, 25'h0, seq_ff, state_ff != FST_IDLE || go_ff, 2'h0};
          `FST_REG_STATUS: s_rdata_out <= {16'h0, sr_view};
          `FST_REG_XSTATUS: s_rdata_out <= {16'h0, xsr_ff};
          `FST_REG_LOCK: s_rdata_out <= {30'h0, lock_ff[1:0]};
          default: begin
            s_rdata_out <= 32'h0;
            s_rresp_out <= 2'h2;
          end
        endcase
      end else if (s_rvalid_out && s_rready_in) begin
        s_rvalid_out <= 1'b0;
      end
    end
  end

  // Assertions
  property p_status_cmd;
    @(posedge sys_clk_in) disable iff (rst_in)
      (state_ff == FST_IDLE && go_ff && op_req_ff == 2'h1)
      |=> (flash_dq_out == `FST_CMD_READ_STATUS && !flash_we_n_out);
  endproperty
  a_status_cmd: assert property (p_status_cmd) else $error("status command not issued");
  property p_sr_mask;
    @(posedge sys_clk_in) disable iff (rst_in) sr_ff[8:0] == 9'h0;
  endproperty
  a_sr_mask: assert property (p_sr_mask) else $error("reserved status bits set");
  property p_xsr_mask;
    @(posedge sys_clk_in) disable iff (rst_in) (xsr_ff & 16'hff7f) == 16'h0;
  endproperty
  a_xsr_mask: assert property (p_xsr_mask) else $error("reserved extended bits set");
  property p_busy_hide;
    @(posedge sys_clk_in) disable iff (rst_in)
      (s_arvalid_in && s_arready_out && reg_idx(s_araddr_in) == `FST_REG_STATUS
        && !sr_ff[`FST_BIT_READY]) |=> s_rdata_out[14:9] == 6'h0;
  endproperty
  a_busy_hide: assert property (p_busy_hide) else $error("error bits shown while busy");
  property p_oe_excl;
    @(posedge sys_clk_in) disable iff (rst_in) !(flash_dq_oe_out && !flash_oe_n_out);
  endproperty
  a_oe_excl: assert property (p_oe_excl) else $error("bus contention on data pins");
  property p_lock_bits;
    @(posedge sys_clk_in) disable iff (rst_in) lock_ff[15:2] == 14'h0;
  endproperty
  a_lock_bits: assert property (p_lock_bits) else $error("lock code wider than two bits");
  sequence s_rd_done;
    state_ff == FST_RD && cnt_ff == 4'h0;
  endsequence
  property p_rd_end;
    @(posedge sys_clk_in) disable iff (rst_in)
      s_rd_done |=> (flash_oe_n_out && state_ff == FST_DONE) ##1 state_ff == FST_IDLE;
  endproperty
  a_rd_end: assert property (p_rd_end) else $error("read cycle did not end");
  property p_wr_len;
    @(posedge sys_clk_in) disable iff (rst_in)
      $fell(flash_we_n_out) |-> !flash_we_n_out [*5] ##1 flash_we_n_out;
  endproperty
  a_wr_len: assert property (p_wr_len) else $error("write pulse length wrong");
endmodule

// ==== fst_flash_model.sv ====
// Behavioural flash device: status words, lock code and protect-pin lock tracking
`timescale 1ns/10ps
`include "fst_defs.svh"
module fst_flash_model (
  // Bus pins
  input wire logic [15:0] dq_in,
  output logic [15:0] dq_out,
  input wire logic ce_n_in,
  input wire logic we_n_in,
  input wire logic oe_n_in,
  input wire logic protect_in,
  output logic busy_n_out,
  // Engine state set by the bench
  input wire logic reset_n_in,
  input wire logic busy_in,
  input wire logic [15:0] raw_sr_in,
  input wire logic [15:0] raw_xsr_in
);
  logic [15:0] mode_ff;
  logic [15:0] last_ff = 16'h0; // Known level before the first read
  logic [1:0] lock_ff;
  logic pin_ff;
  logic from_110_ff;
  logic lock_cmd_ff;
  logic [3:0] err_ff;
  logic [15:0] sr_word;
  logic [15:0] word;
  assign busy_n_out = ~busy_in;
  // Busy keeps junk in the flag bits; the host must not trust them
  assign sr_word = {~busy_in, raw_sr_in[14], raw_sr_in[13] | err_ff[3],
    raw_sr_in[12] | err_ff[2], raw_sr_in[11] | err_ff[1], raw_sr_in[10],
    raw_sr_in[9] | err_ff[0], raw_sr_in[8], 8'h00};
  assign word = (mode_ff == `FST_CMD_PB_SETUP) ? raw_xsr_in :
    (mode_ff == `FST_CMD_READ_ID) ? {14'h0, lock_ff} : sr_word;
  // Released bus shows the inverse of the last word, never a kind value
  assign dq_out = (!oe_n_in && !ce_n_in) ? word : ~last_ff;
  always @(posedge oe_n_in) begin
    last_ff <= word;
  end
  // Commands on the rising write strobe, lock moves on protect edges
  always @(posedge we_n_in or posedge protect_in or negedge protect_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      lock_ff <= 2'b01;
      pin_ff <= 1'b0;
      from_110_ff <= 1'b0;
      lock_cmd_ff <= 1'b0;
      err_ff <= 4'h0;
      mode_ff <= 16'h00ff;
    end else if (protect_in != pin_ff) begin
      pin_ff <= protect_in;
      if (protect_in && lock_ff == 2'b11 && from_110_ff) lock_ff <= 2'b10;
      if (!protect_in) from_110_ff <= (lock_ff == 2'b10);
      if (!protect_in && lock_ff == 2'b10) lock_ff <= 2'b11;
    end else if (!ce_n_in) begin
      mode_ff <= dq_in;
      lock_cmd_ff <= (dq_in == 16'h0060);
      if (lock_cmd_ff && dq_in == 16'h002f) lock_ff <= 2'b11;
      if (lock_cmd_ff && dq_in == 16'h00d0 && protect_in) lock_ff <= {lock_ff[1], 1'b0};
      if (dq_in == `FST_CMD_READ_STATUS && !busy_in) err_ff <= err_ff |
        {raw_sr_in[13], raw_sr_in[12], raw_sr_in[11], raw_sr_in[9]};
      if (dq_in == `FST_CMD_CLEAR_STATUS) err_ff <= 4'h0;
    end
  end
endmodule

// ==== fst_host_test.sv ====
// Self-checking bench for the flash status and lock tracking host controller
`timescale 1ns/10ps
`include "fst_defs.svh"
module fst_host_test;
  localparam logic [31:0] A_CTRL = {26'h0, `FST_REG_CTRL, 2'b00};
  localparam logic [31:0] A_CMD = {26'h0, `FST_REG_CMD, 2'b00};
  localparam logic [31:0] A_SR = {26'h0, `FST_REG_STATUS, 2'b00};
  localparam logic [31:0] A_XSR = {26'h0, `FST_REG_XSTATUS, 2'b00};
  localparam logic [31:0] A_LOCK = {26'h0, `FST_REG_LOCK, 2'b00};
  logic sys_clk_in = 1'b0;
  logic rst_in = 1'b0;
  logic [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0, rdata, rd;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, dq_oe, ce_n, we_n, oe_n, prot, busy_n;
  logic busy = 1'b0;
  logic [2:0] seq0;
  logic [1:0] bresp, rresp, resp;
  logic [22:0] faddr;
  logic [15:0] host_dq, dev_dq, dq_bus, raw_sr = 16'h0, raw_xsr = 16'h0;
  int num_errors = 0;
  int total_checks = 0;
  // Rows: engine busy, raw status with reserved junk, expected status register
  logic [32:0] sr_rows [9] = '{{1'b0, 16'h0000, 16'h8000}, {1'b0, 16'h41ff, 16'hc000},
    {1'b0, 16'h2000, 16'ha000}, {1'b0, 16'h1000, 16'h9000}, {1'b0, 16'h3000, 16'hb000},
    {1'b0, 16'h0800, 16'h8800}, {1'b0, 16'h0400, 16'h8400}, {1'b0, 16'h0200, 16'h8200},
    {1'b1, 16'h7fff, 16'h0000}};
  logic [31:0] xsr_rows [3] = '{{16'hff7f, 16'h0000}, {16'h0080, 16'h0080}, {16'hffff, 16'h0080}};
  // Rows: lock command after 60h or pin level, expected lock code
  logic [18:0] lock_rows [8] = '{{1'b0, 16'h1, 2'b01}, {1'b1, 16'h2f, 2'b11},
    {1'b1, 16'hd0, 2'b10}, {1'b0, 16'h0, 2'b11}, {1'b0, 16'h1, 2'b10},
    {1'b1, 16'h2f, 2'b11}, {1'b0, 16'h0, 2'b11}, {1'b0, 16'h1, 2'b11}};
  assign dq_bus = dq_oe ? host_dq : dev_dq;
  fst_host i_dut (.sys_clk_in(sys_clk_in), .rst_in(rst_in), .s_awaddr_in(awaddr),
    .s_awvalid_in(awvalid), .s_awready_out(awready), .s_wdata_in(wdata), .s_wstrb_in(4'hf),
    .s_wvalid_in(wvalid), .s_wready_out(wready), .s_bresp_out(bresp), .s_bvalid_out(bvalid),
    .s_bready_in(bready), .s_araddr_in(araddr), .s_arvalid_in(arvalid),
    .s_arready_out(arready), .s_rdata_out(rdata), .s_rresp_out(rresp), .s_rvalid_out(rvalid),
    .s_rready_in(rready), .flash_addr_out(faddr), .flash_dq_out(host_dq),
    .flash_dq_oe_out(dq_oe), .flash_dq_in(dq_bus), .flash_ce_n_out(ce_n),
    .flash_we_n_out(we_n), .flash_oe_n_out(oe_n), .protect_accel_pin_out(prot),
    .engine_busy_pin_n_in(busy_n));
  fst_flash_model i_flash (.dq_in(dq_bus), .dq_out(dev_dq), .ce_n_in(ce_n), .we_n_in(we_n),
    .oe_n_in(oe_n), .protect_in(prot), .busy_n_out(busy_n), .reset_n_in(~rst_in),
    .busy_in(busy), .raw_sr_in(raw_sr), .raw_xsr_in(raw_xsr));
  // Clock
  initial begin
    forever #2.5 sys_clk_in = ~sys_clk_in;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected at %0t: got %h, wanted %h", $time, seen, exp);
    end
  endtask
  task automatic axi_wr(input logic [31:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge sys_clk_in);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge sys_clk_in);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    r = bresp;
    bready <= 1'b0;
  endtask
  task automatic axi_rd(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge sys_clk_in);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge sys_clk_in);
      if (arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask
  // Issue one sequencer order and poll until it is no longer busy
  task automatic run_op(input logic [1:0] op, input logic [15:0] data);
    axi_wr(A_CMD, {14'h0, op, data}, resp);
    repeat (40) begin
      axi_rd(A_CMD, rd, resp);
      if (rd[2] === 1'b0) break;
    end
    check({31'h0, rd[2]}, 32'h0);
  endtask
  task automatic conclude();
    $display("checks %0d, errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // Watchdog well beyond the thousand or so cycles the tests need
  initial begin
    repeat (40000) @(posedge sys_clk_in);
    num_errors++;
    conclude();
  end
  initial begin
    rst_in <= 1'b1; // Raised at time zero after the initial low so the flash model sees the edge
    repeat (16) @(posedge sys_clk_in);
    check({29'h0, ce_n, we_n, oe_n}, 32'h7);
    rst_in <= 1'b0;
    foreach (sr_rows[i]) begin
      busy <= sr_rows[i][32];
      raw_sr <= sr_rows[i][31:16];
      run_op(2'd0, `FST_CMD_CLEAR_STATUS);
      run_op(2'd1, 16'h0);
      axi_rd(A_SR, rd, resp);
      check({16'h0, rd[15:0]}, {16'h0, sr_rows[i][15:0]});
    end
    busy <= 1'b0;
    raw_sr <= 16'h2000;
    run_op(2'd1, 16'h0);
    raw_sr <= 16'h0000;
    run_op(2'd1, 16'h0);
    axi_rd(A_SR, rd, resp);
    check({16'h0, rd[15:0]}, 32'ha000);
    run_op(2'd0, `FST_CMD_CLEAR_STATUS);
    run_op(2'd1, 16'h0);
    axi_rd(A_SR, rd, resp);
    check({16'h0, rd[15:0]}, 32'h8000);
    foreach (xsr_rows[i]) begin
      raw_xsr <= xsr_rows[i][31:16];
      run_op(2'd2, 16'h0);
      axi_rd(A_XSR, rd, resp);
      check({16'h0, rd[15:0]}, {16'h0, xsr_rows[i][15:0]});
    end
    axi_wr(A_LOCK, 32'h0012_3456, resp); // Lock reads go to this block address
    foreach (lock_rows[i]) begin
      if (lock_rows[i][18]) begin
        run_op(2'd0, 16'h0060);
        run_op(2'd0, lock_rows[i][17:2]);
      end else axi_wr(A_CTRL, {31'h0, lock_rows[i][2]}, resp);
      run_op(2'd3, 16'h0);
      axi_rd(A_LOCK, rd, resp);
      check({30'h0, rd[1:0]}, {30'h0, lock_rows[i][1:0]});
    end
    axi_rd(A_CTRL, rd, resp);
    check({31'h0, rd[0]}, 32'h1);
    check({9'h0, faddr}, 32'h0012_3456);
    // Unmapped places answer with an error on read only
    axi_rd(32'h0000_0020, rd, resp);
    check({30'h0, resp}, 32'h2);
    axi_wr(32'h0000_0020, 32'h0, resp);
    check({30'h0, resp}, 32'h0);
    // An order written while the sequencer runs is dropped: one op, one count
    axi_rd(A_CMD, rd, resp);
    seq0 = rd[5:3];
    axi_wr(A_CMD, 32'h0001_0000, resp);
    run_op(2'd1, 16'h0);
    check({29'h0, rd[5:3]}, {29'h0, seq0 + 3'h1});
    // Reset with the sequencer idle: pin back low, block comes up locked but not locked-down
    rst_in <= 1'b1;
    repeat (3) @(posedge sys_clk_in);
    check({29'h0, ce_n, we_n, oe_n}, 32'h7);
    rst_in <= 1'b0;
    run_op(2'd3, 16'h0);
    axi_rd(A_LOCK, rd, resp);
    check({30'h0, rd[1:0]}, 32'h1);
    axi_rd(A_CTRL, rd, resp);
    check({31'h0, rd[0]}, 32'h0);
    conclude();
  end
endmodule
